// file: core/cle_engine.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Address-set instructions load the address counter.
// - Data accesses step the counter by one in the entry direction.
// - Status read puts the address counter on data bits 0 to 6.
// - Two-line mode drives 16 commons, one-line 8; always 40 segments.
// - Glyph bits shift into a 40-bit chain, then into a holding latch.
// - A fixed glyph ROM holds 256 characters of 5 by 8 dots.
// - Eight user glyphs of 5 by 8 dots live in writable glyph RAM.
// - Code bits 0 to 2 become glyph RAM address bits 3 to 5.
// - Glyph RAM address bits 0 to 2 pick the row; row eight ORs cursor.
// - Glyph RAM bits 0 to 4 are pixels, bit 4 leftmost, 1 lit.
// - Codes with bits 4 to 7 zero use user glyphs; bit 3 ignored.
// - Clear fills text RAM with 20H, zeroes the counter, long busy.
// - Home zeroes the counter and display shift, keeps text, long busy.
// - Entry mode stores direction and shift bits for later data access.
// - Display control stores display, cursor and blink enables.
// - Shift instruction moves display or cursor, right or left.
// - Function set stores bus width, line count and font height.
// - Glyph address instruction loads six bits and targets glyph RAM.
// - Text address instruction loads seven bits and targets text RAM.
// - Status read returns busy on bit 7; host waits while busy.
// - Data accesses and other instructions keep busy for 18.5 us.
// - Select and direction pick instruction, status, data write or read.
// - In 4-bit mode each byte moves as two nibbles, high first.
// - After a read the next RAM byte is fetched into the data register.
// - Two-line text addresses run 00H-27H and 40H-67H.
module cle_engine #(
	parameter int EXEC_LONG_CYCLES = cle_pkg::EXEC_LONG_CYC,
	parameter int BLINK_CYCLES     = cle_pkg::BLINK_CYC
) (
	// Clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB slave
	input  wire cle_pkg::cle_apb_req_t  apb_req,
	output cle_pkg::cle_apb_rsp_t       apb_rsp,
	// Display drive
	output logic [cle_pkg::SEG_COUNT-1:0] segments,
	output logic [cle_pkg::COM_COUNT-1:0] commons
);
	import cle_pkg::*;

	typedef struct packed {
		logic [6:0]   address_counter;
		logic         glyph_sel;
		logic         inc;
		logic         shift_on;
		logic         disp_on;
		logic         cursor_on;
		logic         blink_on;
		logic         bus_width_select;
		logic         two_line;
		logic         font_tall;
		logic [6:0]   offset;
		logic         busy_flag;
		logic [14:0]  busy_cnt;
		logic [7:0]   data_register;
		logic [7:0]   instruction_register;
		logic         refresh;
		logic         nib_phase;
		logic [3:0]   nib_hi;
		logic         clearing;
		logic [6:0]   clr_addr;
		cle_apb_rsp_t rsp;
		logic [2:0]   pos;
		logic [2:0]   dot;
		logic [3:0]   row;
		logic [15:0]  commons;
		logic [22:0]  blink_cnt;
		logic         blink_ph;
	} cle_core_state_t;

	cle_core_state_t st;
	cle_core_state_t next_st;

	logic [7:0] text_ram [128];
	logic [4:0] glyph_ram [64];

	logic       tram_we;
	logic [6:0] tram_addr;
	logic [7:0] tram_wd;
	logic       gram_we;
	logic [5:0] gram_addr;
	logic [4:0] gram_wd;
	logic       register_select_line;
	cle_acc_t   acc;
	logic       bus_port;
	logic       mapped;
	logic       byte_ok;
	logic [7:0] byte_val;
	logic [7:0] rd_byte;
	logic [6:0] scan_addr;
	logic [7:0] scan_code;
	logic [4:0] rom_row;
	logic [4:0] pattern;
	logic       at_cursor;
	logic       pix;
	logic       seg_load;

	// Step the counter with line wrap in text RAM
	function automatic logic [6:0] step_ac(input logic [6:0] a,
		input logic up, input logic glyph, input logic two);
		logic [6:0] r;
		r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
		if (glyph) begin
			r = {1'b0, r[5:0]};
		end else if (two) begin
			if (up && a == LINE1_LAST) r = LINE2_BASE;
			if (up && a == LINE2_LAST) r = 7'h00;
			if (!up && a == 7'h00) r = LINE2_LAST;
			if (!up && a == LINE2_BASE) r = LINE1_LAST;
		end else begin
			if (up && a == ONE_LINE_LAST) r = 7'h00;
			if (!up && a == 7'h00) r = ONE_LINE_LAST;
		end
		return r;
	endfunction : step_ac

	// Move the display window by one character
	function automatic logic [6:0] shift_off(input logic [6:0] o,
		input logic up, input logic two);
		logic [6:0] span;
		span = two ? SPAN_TWO : SPAN_ONE;
		if (up) begin
			return (7'(o + 7'h01) >= span) ? 7'h00 : 7'(o + 7'h01);
		end
		return (o == 7'h00) ? 7'(span - 7'h01) : 7'(o - 7'h01);
	endfunction : shift_off

	// Text address of one displayed character
	function automatic logic [6:0] char_addr(input logic [6:0] o,
		input logic [2:0] p, input logic line, input logic two);
		logic [6:0] span;
		logic [6:0] s;
		span = two ? SPAN_TWO : SPAN_ONE;
		s = 7'(o + {4'h0, p});
		if (s >= span) s = 7'(s - span);
		return line ? 7'(s + LINE2_BASE) : s;
	endfunction : char_addr

	// Bus decode
	always_comb begin
		register_select_line = apb_req.paddr[RS_BIT];
		bus_port = apb_req.paddr == ADDR_CMD || apb_req.paddr == ADDR_DATA;
		mapped = bus_port || apb_req.paddr == ADDR_MODE;
		unique case ({register_select_line, !apb_req.pwrite})
			2'b00: acc = ACC_INSTR;
			2'b01: acc = ACC_STATUS;
			2'b10: acc = ACC_DWRITE;
			default: acc = ACC_DREAD;
		endcase
		if (register_select_line) begin
			rd_byte = st.data_register;
		end else begin
			rd_byte = {st.busy_flag, st.address_counter};
		end
	end

	// Display scan lookup
	always_comb begin
		scan_addr = char_addr(st.offset, st.pos,
			st.two_line & st.row[3], st.two_line);
		scan_code = text_ram[scan_addr];
		if (scan_code[7:4] == 4'h0) begin
			pattern = glyph_ram[{scan_code[2:0], st.row[2:0]}];
		end else begin
			pattern = rom_row;
		end
		at_cursor = scan_addr == st.address_counter && !st.glyph_sel;
		pix = pattern[3'(LAST_DOT - st.dot)];
		if (at_cursor && st.cursor_on && st.row[2:0] == CURSOR_ROW) begin
			pix = 1'b1;
		end
		if (at_cursor && st.blink_on && st.blink_ph) begin
			pix = 1'b1;
		end
		pix = pix & st.disp_on;
		seg_load = st.pos == LAST_POS && st.dot == LAST_DOT;
	end

	// Next-state logic
	always_comb begin
		next_st = st;
		tram_we = 1'b0;
		tram_addr = st.address_counter;
		tram_wd = SPACE_CODE;
		gram_we = 1'b0;
		gram_addr = st.address_counter[5:0];
		gram_wd = 5'h00;
		byte_ok = 1'b0;
		byte_val = 8'h00;

		// Execution timer
		if (st.busy_flag) begin
			if (st.busy_cnt == 15'h0000) begin
				next_st.busy_flag = 1'b0;
			end else begin
				next_st.busy_cnt = 15'(st.busy_cnt - 15'h0001);
			end
		end

		// Clear fill, one text byte per cycle
		if (st.clearing) begin
			tram_we = 1'b1;
			tram_addr = st.clr_addr;
			tram_wd = SPACE_CODE;
			next_st.clr_addr = 7'(st.clr_addr + 7'h01);
			if (&st.clr_addr) begin
				next_st.clearing = 1'b0;
				next_st.refresh = 1'b1;
			end
		end

		// Fetch the byte at the counter into the data register
		if (st.refresh) begin
			next_st.refresh = 1'b0;
			next_st.data_register = st.glyph_sel ?
				{3'h0, glyph_ram[st.address_counter[5:0]]} :
				text_ram[st.address_counter];
		end

		// APB setup phase prepares the answer
		next_st.rsp.pready = 1'b0;
		if (apb_req.psel && !apb_req.penable) begin
			next_st.rsp.pready = 1'b1;
			next_st.rsp.pslverr = !mapped;
			next_st.rsp.prdata = 32'h0000_0000;
			if (bus_port && !st.bus_width_select) begin
				next_st.rsp.prdata[3:0] = st.nib_phase ?
					rd_byte[3:0] : rd_byte[7:4];
			end else if (bus_port) begin
				next_st.rsp.prdata[7:0] = rd_byte;
			end else if (mapped) begin
				next_st.rsp.prdata[MODE_BUSY] = st.busy_flag;
				next_st.rsp.prdata[MODE_GLYPH] = st.glyph_sel;
				next_st.rsp.prdata[MODE_INC] = st.inc;
				next_st.rsp.prdata[MODE_SHIFT] = st.shift_on;
				next_st.rsp.prdata[MODE_DISP] = st.disp_on;
				next_st.rsp.prdata[MODE_CURSOR] = st.cursor_on;
				next_st.rsp.prdata[MODE_BLINK] = st.blink_on;
				next_st.rsp.prdata[MODE_WIDTH] = st.bus_width_select;
				next_st.rsp.prdata[MODE_LINES] = st.two_line;
				next_st.rsp.prdata[MODE_FONT] = st.font_tall;
				next_st.rsp.prdata[MODE_OFFSET +: 7] = st.offset;
				next_st.rsp.prdata[MODE_INSTR +: 8] =
					st.instruction_register;
			end
		end

		// APB access phase completes a byte or a nibble
		if (apb_req.psel && apb_req.penable && st.rsp.pready && bus_port) begin
			if (!st.bus_width_select && !st.nib_phase) begin
				next_st.nib_phase = 1'b1;
				next_st.nib_hi = apb_req.pwdata[3:0];
			end else begin
				next_st.nib_phase = 1'b0;
				byte_ok = 1'b1;
				byte_val = st.bus_width_select ? apb_req.pwdata[7:0] :
					{st.nib_hi, apb_req.pwdata[3:0]};
			end
		end

		// Execute the completed access unless busy
		if (byte_ok && !st.busy_flag && acc != ACC_STATUS) begin
			next_st.busy_flag = 1'b1;
			next_st.busy_cnt = 15'(EXEC_SHORT_CYC - 1);
			unique case (acc)
				ACC_INSTR: begin
					next_st.instruction_register = byte_val;
					if (byte_val[7]) begin
						next_st.address_counter = byte_val[6:0];
						next_st.glyph_sel = 1'b0;
						next_st.refresh = 1'b1;
					end else if (byte_val[6]) begin
						next_st.address_counter = {1'b0, byte_val[5:0]};
						next_st.glyph_sel = 1'b1;
						next_st.refresh = 1'b1;
					end else if (byte_val[5]) begin
						next_st.bus_width_select = byte_val[FN_WIDTH];
						next_st.two_line = byte_val[FN_LINES];
						next_st.font_tall = byte_val[FN_FONT];
					end else if (byte_val[4]) begin
						if (byte_val[SHF_DISPLAY]) begin
							next_st.offset = shift_off(st.offset,
								!byte_val[SHF_RIGHT], st.two_line);
						end else begin
							next_st.address_counter = step_ac(
								st.address_counter, byte_val[SHF_RIGHT],
								st.glyph_sel, st.two_line);
							next_st.refresh = 1'b1;
						end
					end else if (byte_val[3]) begin
						next_st.disp_on = byte_val[CTL_DISP];
						next_st.cursor_on = byte_val[CTL_CURSOR];
						next_st.blink_on = byte_val[CTL_BLINK];
					end else if (byte_val[2]) begin
						next_st.inc = byte_val[ENTRY_INC];
						next_st.shift_on = byte_val[ENTRY_SHIFT];
					end else if (byte_val[1]) begin
						next_st.address_counter = 7'h00;
						next_st.offset = 7'h00;
						next_st.glyph_sel = 1'b0;
						next_st.refresh = 1'b1;
						next_st.busy_cnt = 15'(EXEC_LONG_CYCLES - 1);
					end else if (byte_val[0]) begin
						next_st.clearing = 1'b1;
						next_st.clr_addr = 7'h00;
						next_st.address_counter = 7'h00;
						next_st.offset = 7'h00;
						next_st.inc = 1'b1;
						next_st.glyph_sel = 1'b0;
						next_st.busy_cnt = 15'(EXEC_LONG_CYCLES - 1);
					end
				end
				ACC_DWRITE: begin
					if (st.glyph_sel) begin
						gram_we = 1'b1;
						gram_wd = byte_val[4:0];
					end else begin
						tram_we = 1'b1;
						tram_wd = byte_val;
						if (st.shift_on) begin
							next_st.offset = shift_off(st.offset, st.inc,
								st.two_line);
						end
					end
					next_st.address_counter = step_ac(st.address_counter,
						st.inc, st.glyph_sel, st.two_line);
					next_st.refresh = 1'b1;
				end
				ACC_DREAD: begin
					next_st.address_counter = step_ac(st.address_counter,
						st.inc, st.glyph_sel, st.two_line);
					next_st.refresh = 1'b1;
				end
				default: begin
					next_st.busy_flag = st.busy_flag;
				end
			endcase
		end

		// Row scan: one dot per cycle, 40 dots per row
		next_st.dot = (st.dot == LAST_DOT) ? 3'h0 : 3'(st.dot + 3'h1);
		if (st.dot == LAST_DOT) begin
			next_st.pos = 3'(st.pos + 3'h1);
		end
		if (seg_load) begin
			next_st.commons = 16'(16'h0001 << st.row);
			if (st.row >= (st.two_line ? LAST_ROW_TWO : LAST_ROW_ONE)) begin
				next_st.row = 4'h0;
			end else begin
				next_st.row = 4'(st.row + 4'h1);
			end
		end

		// Cursor blink phase
		if (st.blink_cnt >= 23'(BLINK_CYCLES - 1)) begin
			next_st.blink_cnt = 23'h000000;
			next_st.blink_ph = !st.blink_ph;
		end else begin
			next_st.blink_cnt = 23'(st.blink_cnt + 23'h000001);
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.inc <= RST_INC;
			st.bus_width_select <= RST_WIDTH8;
		end else begin
			st <= next_st;
		end
	end

	// Text and glyph RAM writes
	always_ff @(posedge pclk) begin
		if (tram_we) begin
			text_ram[tram_addr] <= tram_wd;
		end
		if (gram_we) begin
			glyph_ram[gram_addr] <= gram_wd;
		end
	end

	cle_glyph_rom u_rom (
		.code    (scan_code),
		.row     (st.row[2:0]),
		.pattern (rom_row)
	);

	cle_seg_latch u_seg (
		.pclk     (pclk),
		.presetn  (presetn),
		.bit_in   (pix),
		.load     (seg_load),
		.segments (segments)
	);

	assign apb_rsp = st.rsp;
	assign commons = st.commons;

endmodule : cle_engine

// file: core/cle_glyph_rom.sv
`timescale 1ns/1ps
module cle_glyph_rom (
	// Lookup
	input  wire logic [7:0] code,
	input  wire logic [2:0] row,
	// Pattern row, bit 4 leftmost
	output logic      [4:0] pattern
);
	import cle_pkg::*;

	// Fixed 256 x 8 x 5 table generated from code and row
	always_comb begin
		if (row == CURSOR_ROW) begin
			pattern = 5'h00;
		end else begin
			pattern = code[7:3] ^ {code[2:0], 2'h0} ^ {2'h0, row};
		end
	end

endmodule : cle_glyph_rom

// file: core/cle_seg_latch.sv
`timescale 1ns/1ps
module cle_seg_latch (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// Serial glyph bits
	input  wire logic                          bit_in,
	input  wire logic                          load,
	// Segment drive
	output logic [cle_pkg::SEG_COUNT-1:0] segments
);
	import cle_pkg::*;

	typedef struct packed {
		logic [SEG_COUNT-1:0] chain;
		logic [SEG_COUNT-1:0] hold;
	} cle_seg_state_t;

	cle_seg_state_t st;
	cle_seg_state_t next_st;

	// Shift chain and holding latch
	always_comb begin
		next_st = st;
		next_st.chain = {st.chain[SEG_COUNT-2:0], bit_in};
		if (load) begin
			next_st.hold = next_st.chain;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign segments = st.hold;

endmodule : cle_seg_latch

// file: shared/cle_pkg.sv
package cle_pkg;

	// APB register offsets (byte addresses)
	localparam logic [11:0] ADDR_CMD  = 12'h000;
	localparam logic [11:0] ADDR_DATA = 12'h004;
	localparam logic [11:0] ADDR_MODE = 12'h008;
	localparam int          RS_BIT    = 2;

	// Timing
	localparam int CLK_PERIOD_NS  = 25;
	localparam int EXEC_SHORT_NS  = 18500;
	localparam int EXEC_SHORT_CYC =
		(EXEC_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXEC_LONG_NS   = 760000;
	localparam int EXEC_LONG_CYC  =
		(EXEC_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint BLINK_NS   = 185000000;
	localparam int BLINK_CYC      = int'(BLINK_NS / CLK_PERIOD_NS);

	// Text and glyph layout
	localparam logic [7:0] SPACE_CODE    = 8'h20;
	localparam logic [6:0] LINE2_BASE    = 7'h40;
	localparam logic [6:0] LINE1_LAST    = 7'h27;
	localparam logic [6:0] LINE2_LAST    = 7'h67;
	localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
	localparam logic [6:0] SPAN_TWO      = 7'h28;
	localparam logic [6:0] SPAN_ONE      = 7'h50;
	localparam logic [2:0] CURSOR_ROW    = 3'h7;
	localparam logic [2:0] LAST_DOT      = 3'h4;
	localparam logic [2:0] LAST_POS      = 3'h7;
	localparam logic [3:0] LAST_ROW_TWO  = 4'hF;
	localparam logic [3:0] LAST_ROW_ONE  = 4'h7;
	localparam int         SEG_COUNT     = 40;
	localparam int         COM_COUNT     = 16;

	// Instruction field positions
	localparam int ENTRY_INC   = 1;
	localparam int ENTRY_SHIFT = 0;
	localparam int CTL_DISP    = 2;
	localparam int CTL_CURSOR  = 1;
	localparam int CTL_BLINK   = 0;
	localparam int SHF_DISPLAY = 3;
	localparam int SHF_RIGHT   = 2;
	localparam int FN_WIDTH    = 4;
	localparam int FN_LINES    = 3;
	localparam int FN_FONT     = 2;

	// Mode register field positions
	localparam int MODE_BUSY   = 0;
	localparam int MODE_GLYPH  = 1;
	localparam int MODE_INC    = 2;
	localparam int MODE_SHIFT  = 3;
	localparam int MODE_DISP   = 4;
	localparam int MODE_CURSOR = 5;
	localparam int MODE_BLINK  = 6;
	localparam int MODE_WIDTH  = 7;
	localparam int MODE_LINES  = 8;
	localparam int MODE_FONT   = 9;
	localparam int MODE_OFFSET = 16;
	localparam int MODE_INSTR  = 24;

	// Reset values
	localparam logic RST_INC    = 1'b1;
	localparam logic RST_WIDTH8 = 1'b1;

	typedef enum {ACC_INSTR, ACC_STATUS, ACC_DWRITE, ACC_DREAD} cle_acc_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} cle_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cle_apb_rsp_t;

endpackage : cle_pkg

// file: tb/cle_engine_properties.sv
`timescale 1ns/1ps
module cle_engine_properties
	import cle_pkg::*;
#(
	parameter int EXEC_LONG_CYCLES = 30400,
	parameter int BLINK_CYCLES     = 7400000
) (
	// Clock and reset
	input wire logic                          pclk,
	input wire logic                          presetn,
	// Bus and display
	input wire cle_pkg::cle_apb_req_t         apb_req,
	input wire cle_pkg::cle_apb_rsp_t         apb_rsp,
	input wire logic [cle_pkg::SEG_COUNT-1:0] segments,
	input wire logic [cle_pkg::COM_COUNT-1:0] commons
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic       unmapped;
	logic [5:0] gap;

	assign unmapped = !(apb_req.paddr inside {ADDR_CMD, ADDR_DATA, ADDR_MODE});

	// Cycles since the scanned row last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap <= 6'h00;
		else if ($changed(commons))
			gap <= 6'h00;
		else if (gap != 6'h3F)
			gap <= gap + 6'h01;
	end

	sequence setup_s;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence done_s;
		apb_req.psel && apb_req.penable && apb_rsp.pready;
	endsequence

	chk_ready_after_setup: assert property (
		setup_s |=> done_s) else $error("no answer after setup");
	chk_ready_one_cycle: assert property (
		apb_rsp.pready |=> !apb_rsp.pready) else $error("ready held");
	chk_ready_in_access: assert property (
		apb_rsp.pready |-> apb_req.psel && apb_req.penable)
		else $error("ready outside access");
	chk_unmapped_error: assert property (
		apb_rsp.pready && unmapped |-> apb_rsp.pslverr && apb_rsp.prdata == 0)
		else $error("unmapped access not refused");
	chk_mapped_no_error: assert property (
		apb_rsp.pready && !unmapped |-> !apb_rsp.pslverr)
		else $error("mapped access refused");
	chk_status_byte_only: assert property (
		apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == ADDR_CMD
		|-> apb_rsp.prdata[31:8] == 24'h0) else $error("status too wide");
	chk_commons_onehot: assert property (
		$onehot0(commons)) else $error("several rows driven");
	chk_row_period: assert property (
		$changed(commons) && commons != 0 && $past(commons) != 0
		|-> gap == 6'h27) else $error("row period not 40");
	chk_segments_with_rows: assert property (
		$changed(segments) |-> $changed(commons))
		else $error("segments moved alone");
endmodule : cle_engine_properties

// file: tb/cle_host_model.sv
`timescale 1ns/1ps
module cle_host_model
	import cle_pkg::*;
(
	// Clock
	input wire logic                  pclk,
	// Bus master side
	output cle_pkg::cle_apb_req_t     apb_req,
	input wire cle_pkg::cle_apb_rsp_t apb_rsp
);
	logic        nib;
	logic        err;
	logic [31:0] rd;
	int          cyc;
	int          last_setup;
	int          lapses;

	initial begin
		apb_req = '0;
		nib     = 1'b0;
		cyc     = 0;
		lapses  = 0;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	// One transfer; released lines change so stale values never pass
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		apb_req.psel    <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite  <= w;
		apb_req.paddr   <= a;
		apb_req.pwdata  <= d;
		@(posedge pclk);
		last_setup      = cyc;
		apb_req.penable <= 1'b1;
		do @(posedge pclk); while (apb_rsp.pready !== 1'b1 && n++ < 50);
		if (apb_rsp.pready !== 1'b1) lapses++;
		rd              = apb_rsp.prdata;
		err             = apb_rsp.pslverr;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
		apb_req.paddr   <= ~a;
		apb_req.pwdata  <= ~d;
	endtask : xfer

	// Byte moves, high nibble first on the narrow bus
	task automatic put(input logic [11:0] a, input logic [7:0] b);
		if (nib) begin
			xfer(1'b1, a, {28'h0, b[7:4]});
			xfer(1'b1, a, {28'h0, b[3:0]});
		end else
			xfer(1'b1, a, {24'h0, b});
	endtask : put
	task automatic get(input logic [11:0] a, output logic [7:0] b);
		if (nib) begin
			xfer(1'b0, a, 32'h0);
			b[7:4] = rd[3:0];
			xfer(1'b0, a, 32'h0);
			b[3:0] = rd[3:0];
		end else begin
			xfer(1'b0, a, 32'h0);
			b = rd[7:0];
		end
	endtask : get

	// Poll status until the engine is free
	task automatic wait_idle();
		logic [7:0] s;
		int         n;
		n = 0;
		do get(ADDR_CMD, s); while (s[7] !== 1'b0 && n++ < 2000);
		if (s[7] !== 1'b0) lapses++;
	endtask : wait_idle
endmodule : cle_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cle_pkg::*;
	localparam int LONG = 200;
	logic                 pclk;
	logic                 presetn;
	cle_apb_req_t         apb_req;
	cle_apb_rsp_t         apb_rsp;
	logic [SEG_COUNT-1:0] segments;
	logic [COM_COUNT-1:0] commons;
	int                   fails;
	int                   checks_done;
	int                   seed;
	logic [7:0]           r;
	logic [7:0]           a;
	logic [7:0]           q [4];

	cle_engine #(.EXEC_LONG_CYCLES(LONG), .BLINK_CYCLES(64)) u_cle_engine (
		.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .segments(segments), .commons(commons));
	cle_host_model host (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

	// Bus clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// Busy time expected for one access
	function automatic int exec_cycles(input logic w, input logic [11:0] ad,
		input logic [7:0] v);
		if (w && ad == ADDR_CMD && v != 8'h00 && v[7:2] == 6'h00)
			return LONG;
		return EXEC_SHORT_CYC;
	endfunction : exec_cycles

	// One byte access, then poll busy and time it
	task automatic acc(input logic w, input logic [11:0] ad,
		input logic [7:0] v);
		int t0;
		int lo;
		if (w)
			host.put(ad, v);
		else
			host.get(ad, r);
		t0 = host.cyc;
		lo = exec_cycles(w, ad, v);
		host.wait_idle();
		t0 = host.last_setup - t0;
		check(32'(t0 >= lo && t0 <= lo + 9), 32'h1);
	endtask : acc

	task automatic stat(input logic [7:0] exp);
		host.get(ADDR_CMD, r);
		check(32'(r), 32'(exp));
	endtask : stat

	// Gather the rows driven and any lit dot over one whole frame
	task automatic sweep(input logic [15:0] exp_rows, input logic lit);
		logic [COM_COUNT-1:0] c;
		logic [SEG_COUNT-1:0] s;
		c = '0;
		s = '0;
		repeat (700) begin
			@(negedge pclk);
			c = c | commons;
			s = s | segments;
		end
		check(32'(c), 32'(exp_rows));
		check(32'(s != '0), 32'(lit));
	endtask : sweep

	task automatic mode_is(input logic [31:0] exp);
		host.xfer(1'b0, ADDR_MODE, 32'h0);
		check(host.rd & 32'h3FF, exp);
	endtask : mode_is

	task automatic end_of_test();
		fails += host.lapses;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	initial begin
		seed        = 32'hA84C;
		fails       = 0;
		checks_done = 0;
		presetn     = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		mode_is(32'h084);
		sweep(16'h00FF, 1'b0);
		host.xfer(1'b0, 12'h00C, 32'h0);
		check(32'(host.err), 32'h1);
		host.xfer(1'b1, ADDR_MODE, 32'hFFFF_FFFF);
		mode_is(32'h084);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 8'h4F : 8'(($random(seed) & 32'hFF) % 80);
			acc(1'b1, ADDR_CMD, 8'h80 | a);
			stat(a);
			acc(1'b1, ADDR_CMD, 8'h40 | (a & 8'h3F));
			stat(a & 8'h3F);
		end
		$display("address test done");
		a = 8'(($random(seed) & 32'hFF) % 70);
		acc(1'b1, ADDR_CMD, 8'h80 | a);
		foreach (q[i]) begin
			q[i] = 8'($random(seed));
			acc(1'b1, ADDR_DATA, q[i]);
		end
		stat(a + 8'h04);
		acc(1'b1, ADDR_CMD, 8'h80 | a);
		foreach (q[i]) begin
			acc(1'b0, ADDR_DATA, 8'h00);
			check(32'(r), 32'(q[i]));
		end
		acc(1'b1, ADDR_CMD, 8'h04);
		acc(1'b1, ADDR_DATA, 8'h55);
		stat(a + 8'h03);
		$display("data test done");
		acc(1'b1, ADDR_CMD, 8'h18);
		host.xfer(1'b0, ADDR_MODE, 32'h0);
		check(32'(host.rd[22:16] != 7'h00), 32'h1);
		stat(a + 8'h03);
		acc(1'b1, ADDR_CMD, 8'h14);
		stat(a + 8'h04);
		acc(1'b1, ADDR_CMD, 8'h03);
		stat(8'h00);
		host.xfer(1'b0, ADDR_MODE, 32'h0);
		check(32'(host.rd[22:16]), 32'h0);
		acc(1'b1, ADDR_CMD, 8'h80 | a);
		acc(1'b0, ADDR_DATA, 8'h00);
		check(32'(r), 32'(q[0]));
		acc(1'b1, ADDR_CMD, 8'h01);
		stat(8'h00);
		acc(1'b1, ADDR_CMD, 8'h80 | a);
		acc(1'b0, ADDR_DATA, 8'h00);
		check(32'(r), 32'h20);
		$display("clear test done");
		acc(1'b1, ADDR_CMD, 8'h07);
		acc(1'b1, ADDR_DATA, 8'h41);
		host.xfer(1'b0, ADDR_MODE, 32'h0);
		check(32'(host.rd[22:16]), 32'h1);
		a = 8'($random(seed) & 32'h3E);
		acc(1'b1, ADDR_CMD, 8'h40 | a);
		acc(1'b1, ADDR_DATA, q[1]);
		stat(a + 8'h01);
		acc(1'b1, ADDR_CMD, 8'h40 | a);
		acc(1'b0, ADDR_DATA, 8'h00);
		check(32'(r), 32'(q[1] & 8'h1F));
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, ADDR_CMD, 8'h08 | 8'(i));
			host.xfer(1'b0, ADDR_MODE, 32'h0);
			check(32'(host.rd[6:4]), 32'({i[0], i[1], i[2]}));
		end
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, ADDR_CMD, 8'h30 | 8'(i << 2));
			host.xfer(1'b0, ADDR_MODE, 32'h0);
			check(32'(host.rd[9:7]), 32'({i[0], i[1], 1'b1}));
		end
		acc(1'b1, ADDR_CMD, 8'hA7);
		acc(1'b1, ADDR_CMD, 8'h14);
		stat(8'h40);
		acc(1'b1, ADDR_CMD, 8'h02);
		sweep(16'hFFFF, 1'b1);
		acc(1'b1, ADDR_CMD, 8'h00);
		$display("mode test done");
		host.put(ADDR_CMD, 8'h87);
		host.put(ADDR_CMD, 8'h89);
		host.wait_idle();
		stat(8'h07);
		host.put(ADDR_CMD, 8'h28);
		host.nib = 1'b1;
		host.wait_idle();
		acc(1'b1, ADDR_CMD, 8'hC3);
		stat(8'h43);
		$display("bus test done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		host.nib = 1'b0;
		mode_is(32'h084);
		$display("second reset test done");
		end_of_test();
	end

	// Hang guard
	initial begin
		#(100000 * 25);
		fails++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule : testbench

bind cle_engine cle_engine_properties #(
	.EXEC_LONG_CYCLES(EXEC_LONG_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)
) u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .segments(segments), .commons(commons));
